/* File: design/fabric_params.svh */
// constants of the core memory bus fabric and its conversion trigger path
`ifndef FABRIC_PARAMS_SVH
`define FABRIC_PARAMS_SVH

// bus widths
`define XA_W      24
`define PA_W      21
`define DW_W      16
`define LW_W      32
`define XA_MSB    23

// address segment decode: top byte of the data address
`define SEG_HI    23
`define SEG_LO    16
`define PER_SEG   8'hFF
`define FL_SEG    8'h01

// trigger timer counter width and zero value, and the zero upper half of 16-bit reads
`define TRG_W     16
`define TRG_ZERO  16'h0000
`define HALF_ZERO 16'h0000

`endif

/* File: design/fabric_pkg.sv */
// types of the core memory bus fabric
`include "fabric_params.svh"
package fabric_pkg;

    // access size driven by the core with each primary access
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} acc_size_e;

    // target of a primary data access
    typedef enum logic [1:0] {TGT_RAM, TGT_FLASH, TGT_PER} tgt_e;

    // trigger timer state in the delayed mode
    typedef enum logic {TRG_IDLE, TRG_DELAY} trig_st_e;

    // whole state of the fabric
    typedef struct packed {
        logic [`PA_W-1:0]  pm_addr;
        logic              pm_rd;
        logic              pm_wr;
        logic [`DW_W-1:0]  pm_wdata;
        logic              pm_pend;
        logic              pm_vld;
        logic [`DW_W-1:0]  pm_rdata;
        logic [`XA_W-1:0]  a_addr;
        acc_size_e         a_size;
        logic [`LW_W-1:0]  a_wdata;
        logic              ram_rd;
        logic              ram_wr;
        logic              fl_rd;
        logic              fl_wr;
        logic              per_rd;
        logic              per_wr;
        tgt_e              a_tgt;
        tgt_e              a_ptgt;
        logic              a_pend;
        logic              a_vld;
        logic [`LW_W-1:0]  a_rdata;
        logic [`XA_W-1:0]  b_addr;
        logic              b_rd;
        logic              b_pend;
        logic              b_vld;
        logic [`DW_W-1:0]  b_rdata;
        logic              hold;
        trig_st_e          tst;
        logic [`TRG_W-1:0] tcnt;
        logic [`TRG_W-1:0] pcnt;
        logic              adc;
    } fabric_s;

endpackage

/* File: design/core_memory_bus_fabric.sv */
// core memory bus fabric with conversion trigger timer
`timescale 1ns/1ps
`include "fabric_params.svh"
module core_memory_bus_fabric (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // program memory side of the core
    input  wire logic [`PA_W-1:0]   prog_addr_i,
    input  wire logic               prog_rd_i,
    input  wire logic               prog_wr_i,
    output logic      [`DW_W-1:0]   prog_rdata_o,
    output logic                    prog_vld_o,
    // primary data side of the core
    input  wire logic [`XA_W-1:0]   x1_addr_i,
    input  wire logic [1:0]         x1_size_i,
    input  wire logic               x1_rd_i,
    input  wire logic               x1_wr_i,
    input  wire logic [`LW_W-1:0]   x1_wdata_i,
    output logic      [`LW_W-1:0]   x1_rdata_o,
    output logic                    x1_vld_o,
    // secondary data side of the core
    input  wire logic [`XA_W-1:0]   x2_addr_i,
    input  wire logic               x2_rd_i,
    output logic      [`DW_W-1:0]   x2_rdata_o,
    output logic                    x2_vld_o,
    output logic                    stall_o,
    // program memory
    output logic      [`PA_W-1:0]   pm_addr_o,
    output logic                    pm_rd_o,
    output logic                    pm_wr_o,
    output logic      [`DW_W-1:0]   pm_wdata_o,
    input  wire logic [`DW_W-1:0]   pm_rdata_i,
    // data memory, 32-bit primary port and 16-bit secondary port
    output logic      [`XA_W-1:0]   dm_a_addr_o,
    output logic      [1:0]         dm_a_size_o,
    output logic                    dm_a_rd_o,
    output logic                    dm_a_wr_o,
    output logic      [`LW_W-1:0]   dm_a_wdata_o,
    input  wire logic [`LW_W-1:0]   dm_a_rdata_i,
    output logic      [`XA_W-1:0]   dm_b_addr_o,
    output logic                    dm_b_rd_o,
    input  wire logic [`DW_W-1:0]   dm_b_rdata_i,
    // flash array, direct data path
    output logic      [`XA_W-1:0]   fl_addr_o,
    output logic                    fl_rd_o,
    output logic                    fl_wr_o,
    output logic      [`DW_W-1:0]   fl_wdata_o,
    input  wire logic [`DW_W-1:0]   fl_rdata_i,
    // peripheral register bus
    output logic      [`XA_W-1:0]   per_addr_o,
    output logic                    per_rd_o,
    output logic                    per_wr_o,
    output logic      [`DW_W-1:0]   per_wdata_o,
    input  wire logic [`DW_W-1:0]   per_rdata_i,
    // conversion trigger path
    input  wire logic               alt_mode_i,
    input  wire logic               pwm_reload_i,
    input  wire logic [`TRG_W-1:0]  period_i,
    input  wire logic [`TRG_W-1:0]  delay_i,
    output logic                    adc_start_o
);

    fabric_pkg::fabric_s s_r;
    fabric_pkg::fabric_s s_nxt;
    logic [`XA_W-1:0]    a_addr;
    logic [`SEG_HI-`SEG_LO:0] seg;
    fabric_pkg::tgt_e    tgt;
    logic                conflict;

    // ************************************************************
    // primary address shaping and decode
    // ************************************************************

    // byte accesses live in the lower half only
    always_comb begin
        a_addr = x1_addr_i;
        if (fabric_pkg::acc_size_e'(x1_size_i) == fabric_pkg::SZ_BYTE)
            a_addr[`XA_MSB] = 1'b0;
        seg = a_addr[`SEG_HI:`SEG_LO];
        if (seg == `PER_SEG)
            tgt = fabric_pkg::TGT_PER;
        else if (seg == `FL_SEG)
            tgt = fabric_pkg::TGT_FLASH;
        else
            tgt = fabric_pkg::TGT_RAM;
    end

    // a ram write and a secondary read of the same word would race
    // inside the memory, so the secondary read is pushed back a cycle
    assign conflict = x1_wr_i && x2_rd_i && !s_r.hold
                      && tgt == fabric_pkg::TGT_RAM
                      && (x2_addr_i == a_addr
                          || (fabric_pkg::acc_size_e'(x1_size_i)
                              == fabric_pkg::SZ_LONG
                              && x2_addr_i[`XA_W-1:1]
                                 == a_addr[`XA_W-1:1]));

    // ************************************************************
    // next state
    // ************************************************************

    // strobes are one-cycle pulses; reads return two cycles later
    always_comb begin
        s_nxt        = s_r;
        s_nxt.pm_rd  = 1'b0;
        s_nxt.pm_wr  = 1'b0;
        s_nxt.ram_rd = 1'b0;
        s_nxt.ram_wr = 1'b0;
        s_nxt.fl_rd  = 1'b0;
        s_nxt.fl_wr  = 1'b0;
        s_nxt.per_rd = 1'b0;
        s_nxt.per_wr = 1'b0;
        s_nxt.b_rd   = 1'b0;
        s_nxt.hold   = 1'b0;
        s_nxt.adc    = 1'b0;
        // read return: same latency for ram, flash and peripherals
        s_nxt.pm_pend = s_r.pm_rd;
        s_nxt.pm_vld  = s_r.pm_pend;
        if (s_r.pm_pend)
            s_nxt.pm_rdata = pm_rdata_i;
        s_nxt.a_pend = s_r.ram_rd | s_r.fl_rd | s_r.per_rd;
        // target travels with its read, so a back-to-back request to
        // another target cannot steer the returning data
        s_nxt.a_ptgt = s_r.a_tgt;
        s_nxt.a_vld  = s_r.a_pend;
        if (s_r.a_pend) begin
            unique case (s_r.a_ptgt)
                fabric_pkg::TGT_RAM:
                    s_nxt.a_rdata = dm_a_rdata_i;
                fabric_pkg::TGT_FLASH:
                    s_nxt.a_rdata = {`HALF_ZERO, fl_rdata_i};
                default:
                    s_nxt.a_rdata = {`HALF_ZERO, per_rdata_i};
            endcase
        end
        s_nxt.b_pend = s_r.b_rd;
        s_nxt.b_vld  = s_r.b_pend;
        if (s_r.b_pend)
            s_nxt.b_rdata = dm_b_rdata_i;
        // issue: a held secondary read owns the stall cycle
        if (s_r.hold) begin
            s_nxt.b_rd = 1'b1;
        end else begin
            if (prog_rd_i || prog_wr_i) begin
                s_nxt.pm_addr  = prog_addr_i;
                s_nxt.pm_rd    = prog_rd_i;
                s_nxt.pm_wr    = prog_wr_i;
                s_nxt.pm_wdata = x1_wdata_i[`DW_W-1:0];
            end
            if (x1_rd_i || x1_wr_i) begin
                s_nxt.a_addr  = a_addr;
                s_nxt.a_size  = fabric_pkg::acc_size_e'(x1_size_i);
                s_nxt.a_wdata = x1_wdata_i;
                s_nxt.a_tgt   = tgt;
                unique case (tgt)
                    fabric_pkg::TGT_RAM: begin
                        s_nxt.ram_rd = x1_rd_i;
                        s_nxt.ram_wr = x1_wr_i;
                    end
                    fabric_pkg::TGT_FLASH: begin
                        s_nxt.fl_rd = x1_rd_i;
                        s_nxt.fl_wr = x1_wr_i;
                    end
                    default: begin
                        s_nxt.per_rd = x1_rd_i;
                        s_nxt.per_wr = x1_wr_i;
                    end
                endcase
            end
            if (x2_rd_i) begin
                s_nxt.b_addr = x2_addr_i;
                s_nxt.b_rd   = !conflict;
                s_nxt.hold   = conflict;
            end
        end
        // conversion trigger: periodic or delayed from reload sync
        if (!alt_mode_i) begin
            s_nxt.tst = fabric_pkg::TRG_IDLE;
            if (s_r.pcnt == `TRG_ZERO) begin
                s_nxt.pcnt = period_i;
                s_nxt.adc  = 1'b1;
            end else begin
                s_nxt.pcnt = s_r.pcnt - 1'b1;
            end
        end else begin
            s_nxt.pcnt = period_i;
            unique case (s_r.tst)
                fabric_pkg::TRG_IDLE:
                    if (pwm_reload_i) begin
                        s_nxt.tcnt = delay_i;
                        s_nxt.tst  = fabric_pkg::TRG_DELAY;
                    end
                fabric_pkg::TRG_DELAY:
                    if (s_r.tcnt == `TRG_ZERO) begin
                        s_nxt.adc = 1'b1;
                        s_nxt.tst = fabric_pkg::TRG_IDLE;
                    end else begin
                        s_nxt.tcnt = s_r.tcnt - 1'b1;
                    end
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    // everything clears on reset so no strobe leaks out
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // outputs, all straight from the state register
    // ************************************************************

    // shared address and data registers fan out to each target
    assign prog_rdata_o = s_r.pm_rdata;
    assign prog_vld_o   = s_r.pm_vld;
    assign x1_rdata_o   = s_r.a_rdata;
    assign x1_vld_o     = s_r.a_vld;
    assign x2_rdata_o   = s_r.b_rdata;
    assign x2_vld_o     = s_r.b_vld;
    assign stall_o      = s_r.hold;
    assign pm_addr_o    = s_r.pm_addr;
    assign pm_rd_o      = s_r.pm_rd;
    assign pm_wr_o      = s_r.pm_wr;
    assign pm_wdata_o   = s_r.pm_wdata;
    assign dm_a_addr_o  = s_r.a_addr;
    assign dm_a_size_o  = s_r.a_size;
    assign dm_a_rd_o    = s_r.ram_rd;
    assign dm_a_wr_o    = s_r.ram_wr;
    assign dm_a_wdata_o = s_r.a_wdata;
    assign dm_b_addr_o  = s_r.b_addr;
    assign dm_b_rd_o    = s_r.b_rd;
    assign fl_addr_o    = s_r.a_addr;
    assign fl_rd_o      = s_r.fl_rd;
    assign fl_wr_o      = s_r.fl_wr;
    assign fl_wdata_o   = s_r.a_wdata[`DW_W-1:0];
    assign per_addr_o   = s_r.a_addr;
    assign per_rd_o     = s_r.per_rd;
    assign per_wr_o     = s_r.per_wr;
    assign per_wdata_o  = s_r.a_wdata[`DW_W-1:0];
    assign adc_start_o  = s_r.adc;

    // ************************************************************
    // assertions
    // ************************************************************

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // the edge that releases reset still samples reset high
    periodic_sync_a: assert property (
        !rst_i && !alt_mode_i && s_r.pcnt == `TRG_ZERO |=> adc_start_o)
        else $error("periodic sync pulse missing");
    reload_route_a: assert property (
        alt_mode_i && pwm_reload_i && s_r.tst == fabric_pkg::TRG_IDLE
        |=> s_r.tst == fabric_pkg::TRG_DELAY
            && s_r.tcnt == $past(delay_i))
        else $error("reload sync did not start delay");
    delay_done_a: assert property (
        alt_mode_i && $past(alt_mode_i) && adc_start_o
        |-> $past(s_r.tcnt) == `TRG_ZERO
            && $past(s_r.tst) == fabric_pkg::TRG_DELAY)
        else $error("conversion start before delay end");
    prog_wdata_a: assert property (
        prog_wr_i && !stall_o |=> pm_wr_o
            && pm_wdata_o == $past(x1_wdata_i[`DW_W-1:0]))
        else $error("program write data not low half");
    prog_read_a: assert property (
        pm_rd_o |-> ##2 prog_vld_o && prog_rdata_o == $past(pm_rdata_i))
        else $error("program read data lost");
    ram_read_a: assert property (
        dm_a_rd_o |-> ##2 x1_vld_o && x1_rdata_o == $past(dm_a_rdata_i))
        else $error("primary ram read data lost");
    sec_read_a: assert property (
        dm_b_rd_o |-> ##2 x2_vld_o && x2_rdata_o == $past(dm_b_rdata_i))
        else $error("secondary read data lost");
    per_read_a: assert property (
        per_rd_o |-> ##2 x1_vld_o
            && x1_rdata_o == {`HALF_ZERO, $past(per_rdata_i)})
        else $error("peripheral read not at memory rate");
    per_write_a: assert property (
        per_wr_o |-> per_wdata_o == $past(x1_wdata_i[`DW_W-1:0])
            && !dm_a_wr_o)
        else $error("peripheral write data mismatch");
    byte_msb_a: assert property (
        (x1_rd_i || x1_wr_i) && !stall_o
        && x1_size_i == fabric_pkg::SZ_BYTE |=> !dm_a_addr_o[`XA_MSB])
        else $error("byte access top address bit set");
    flash_direct_a: assert property (
        fl_rd_o || fl_wr_o |-> !dm_a_rd_o && !per_rd_o && !per_wr_o)
        else $error("flash access leaked to other port");
    collide_stall_a: assert property (
        conflict |=> stall_o && !dm_b_rd_o ##1 dm_b_rd_o && !stall_o)
        else $error("colliding secondary read not deferred");

    periodic_c: cover property (!alt_mode_i ##1 adc_start_o);
    delayed_c:  cover property (alt_mode_i && pwm_reload_i
                                ##[1:8] adc_start_o);
    collide_c:  cover property (conflict ##2 x2_vld_o);
    dual_c:     cover property (dm_a_rd_o && dm_b_rd_o && pm_rd_o);

endmodule

/* File: test/mem_model.sv */
// memory and peripheral responder model facing the fabric
`timescale 1ns/1ps
`include "fabric_params.svh"
module mem_model (
    input  wire logic             clk_i,
    input  wire logic [`PA_W-1:0] pm_addr_i,
    input  wire logic             pm_rd_i,
    input  wire logic [`XA_W-1:0] dm_a_addr_i,
    input  wire logic             dm_a_rd_i,
    input  wire logic [`XA_W-1:0] dm_b_addr_i,
    input  wire logic             dm_b_rd_i,
    input  wire logic [`XA_W-1:0] fl_addr_i,
    input  wire logic             fl_rd_i,
    input  wire logic [`XA_W-1:0] per_addr_i,
    input  wire logic             per_rd_i,
    output logic      [`DW_W-1:0] pm_rdata_o,
    output logic      [`LW_W-1:0] dm_a_rdata_o,
    output logic      [`DW_W-1:0] dm_b_rdata_o,
    output logic      [`DW_W-1:0] fl_rdata_o,
    output logic      [`DW_W-1:0] per_rdata_o
);
    // ************************************************
    // read responders
    // ************************************************
    initial begin
        pm_rdata_o = 16'h0000;
        dm_a_rdata_o = 32'h00000000;
        dm_b_rdata_o = 16'h0000;
        fl_rdata_o = 16'h0000;
        per_rdata_o = 16'h0000;
    end
    // data valid the cycle after a strobe; otherwise lines toggle
    // so a late sample never matches by luck
    always @(posedge clk_i) begin
        pm_rdata_o <= pm_rd_i ? pm_addr_i[15:0] ^ 16'h0F0F : ~pm_rdata_o;
        dm_a_rdata_o <= dm_a_rd_i ? {dm_a_addr_i[15:0] ^ 16'hC3C3,
                        dm_a_addr_i[15:0]} : ~dm_a_rdata_o;
        dm_b_rdata_o <= dm_b_rd_i ? dm_b_addr_i[15:0] ^ 16'h3C3C
                        : ~dm_b_rdata_o;
        fl_rdata_o <= fl_rd_i ? fl_addr_i[15:0] ^ 16'h9696
                      : ~fl_rdata_o;
        per_rdata_o <= per_rd_i ? per_addr_i[15:0] ^ 16'h5A5A
                       : ~per_rdata_o;
    end
endmodule

/* File: test/core_memory_bus_fabric_tb.sv */
// self-checking bench of the core memory bus fabric
`timescale 1ns/1ps
`include "fabric_params.svh"
module core_memory_bus_fabric_tb;
    // ************************************************
    // signals
    // ************************************************
    logic             clk_i = 1'b0, rst_i = 1'b1;
    logic [`PA_W-1:0] prog_addr_i = '0, pm_addr_o;
    logic             prog_rd_i = 1'b0, prog_wr_i = 1'b0;
    logic [`XA_W-1:0] x1_addr_i = '0, x2_addr_i = '0;
    logic [1:0]       x1_size_i = 2'h0, dm_a_size_o;
    logic             x1_rd_i = 1'b0, x1_wr_i = 1'b0, x2_rd_i = 1'b0;
    logic [`LW_W-1:0] x1_wdata_i = '0, x1_rdata_o, dm_a_wdata_o;
    logic [`LW_W-1:0] dm_a_rdata_i;
    logic [`DW_W-1:0] prog_rdata_o, x2_rdata_o, pm_wdata_o, pm_rdata_i;
    logic [`DW_W-1:0] fl_wdata_o, per_wdata_o, dm_b_rdata_i;
    logic [`DW_W-1:0] fl_rdata_i, per_rdata_i;
    logic [`XA_W-1:0] dm_a_addr_o, dm_b_addr_o, fl_addr_o, per_addr_o;
    logic             prog_vld_o, x1_vld_o, x2_vld_o, stall_o, pm_rd_o;
    logic             pm_wr_o, dm_a_rd_o, dm_a_wr_o, dm_b_rd_o, fl_rd_o;
    logic             fl_wr_o, per_rd_o, per_wr_o, adc_start_o;
    logic             alt_mode_i = 1'b0, pwm_reload_i = 1'b0;
    logic [`TRG_W-1:0] period_i = 16'h0005, delay_i = 16'h0004;
    int               mismatches = 0, check_count = 0;

    core_memory_bus_fabric uut (.clk_i, .rst_i, .prog_addr_i, .prog_rd_i,
        .prog_wr_i, .prog_rdata_o, .prog_vld_o, .x1_addr_i, .x1_size_i,
        .x1_rd_i, .x1_wr_i, .x1_wdata_i, .x1_rdata_o, .x1_vld_o,
        .x2_addr_i, .x2_rd_i, .x2_rdata_o, .x2_vld_o, .stall_o, .pm_addr_o,
        .pm_rd_o, .pm_wr_o, .pm_wdata_o, .pm_rdata_i, .dm_a_addr_o,
        .dm_a_size_o, .dm_a_rd_o, .dm_a_wr_o, .dm_a_wdata_o, .dm_a_rdata_i,
        .dm_b_addr_o, .dm_b_rd_o, .dm_b_rdata_i, .fl_addr_o, .fl_rd_o,
        .fl_wr_o, .fl_wdata_o, .fl_rdata_i, .per_addr_o, .per_rd_o,
        .per_wr_o, .per_wdata_o, .per_rdata_i, .alt_mode_i, .pwm_reload_i,
        .period_i, .delay_i, .adc_start_o);

    mem_model mem (.clk_i, .pm_addr_i(pm_addr_o), .pm_rd_i(pm_rd_o),
        .dm_a_addr_i(dm_a_addr_o), .dm_a_rd_i(dm_a_rd_o),
        .dm_b_addr_i(dm_b_addr_o), .dm_b_rd_i(dm_b_rd_o),
        .fl_addr_i(fl_addr_o), .fl_rd_i(fl_rd_o), .per_addr_i(per_addr_o),
        .per_rd_i(per_rd_o), .pm_rdata_o(pm_rdata_i),
        .dm_a_rdata_o(dm_a_rdata_i), .dm_b_rdata_o(dm_b_rdata_i),
        .fl_rdata_o(fl_rdata_i), .per_rdata_o(per_rdata_i));

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic flag(input int k);
        case (k)
            0: return x1_vld_o;
            1: return x2_vld_o;
            2: return prog_vld_o;
            default: return adc_start_o;
        endcase
    endfunction

    // counts edges until the pulse shows; bounded so a hang ends the run
    task automatic wait_flag(input int k, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (flag(k) !== 1'b1 && n < 20);
        chk("pulse seen", flag(k), 1'b1);
        if (flag(k) !== 1'b1) end_of_test();
    endtask

    // op bits: x1 read, x1 write, x2 read, prog read, prog write
    task automatic go(input logic [4:0] op, input logic [23:0] a,
                      input logic [1:0] sz, input logic [31:0] wd);
        @(posedge clk_i);
        {prog_wr_i, prog_rd_i, x2_rd_i, x1_wr_i, x1_rd_i} <= op;
        x1_addr_i <= a;
        x2_addr_i <= a;
        prog_addr_i <= a[20:0];
        x1_size_i <= sz;
        x1_wdata_i <= wd;
        @(posedge clk_i);
        {prog_wr_i, prog_rd_i, x2_rd_i, x1_wr_i, x1_rd_i} <= 5'h00;
        #1;
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_primary();
        int n;
        go(5'h01, 24'h001234, 2'h2, 32'h0);
        chk("dm_a_rd", dm_a_rd_o, 1'b1);
        chk("dm_a_size", dm_a_size_o, 2'h2);
        wait_flag(0, n);
        chk("ram latency", n, 2);
        chk("x1_rdata", x1_rdata_o, 32'hD1F71234);
        go(5'h01, 24'h800010, 2'h0, 32'h0);
        chk("byte addr", dm_a_addr_o, 24'h000010);
        wait_flag(0, n);
        go(5'h01, 24'h800010, 2'h1, 32'h0);
        chk("word addr", dm_a_addr_o, 24'h800010);
        wait_flag(0, n);
        go(5'h02, 24'h000100, 2'h2, 32'hDEADBEEF);
        chk("dm_a_wr", dm_a_wr_o, 1'b1);
        chk("dm_a_wdata", dm_a_wdata_o, 32'hDEADBEEF);
        repeat (4) @(posedge clk_i);
    endtask

    task automatic t_periph_flash();
        int n;
        go(5'h02, 24'hFF0004, 2'h1, 32'h1234ABCD);
        chk("per_wr", per_wr_o, 1'b1);
        chk("per_wdata", per_wdata_o, 16'hABCD);
        chk("per_addr", per_addr_o, 24'hFF0004);
        repeat (4) @(posedge clk_i);
        go(5'h01, 24'hFF0006, 2'h1, 32'h0);
        chk("per_rd", per_rd_o, 1'b1);
        wait_flag(0, n);
        chk("per latency", n, 2);
        chk("per rdata", x1_rdata_o, 32'h00005A5C);
        go(5'h01, 24'h010008, 2'h1, 32'h0);
        chk("fl_rd", fl_rd_o, 1'b1);
        chk("fl_addr", fl_addr_o, 24'h010008);
        chk("no per_rd", per_rd_o, 1'b0);
        wait_flag(0, n);
        chk("fl rdata", x1_rdata_o, 32'h0000969E);
        go(5'h02, 24'h01000A, 2'h1, 32'h0000BEEF);
        chk("fl_wdata", {fl_wr_o, fl_wdata_o}, 17'h1BEEF);
        repeat (4) @(posedge clk_i);
    endtask

    task automatic t_prog_sec();
        int n;
        go(5'h10, 24'h01ABCD, 2'h1, 32'hFFFF1357);
        chk("pm_wr", pm_wr_o, 1'b1);
        chk("pm_wdata", pm_wdata_o, 16'h1357);
        chk("pm_addr", pm_addr_o, 21'h01ABCD);
        repeat (4) @(posedge clk_i);
        go(5'h08, 24'h010002, 2'h1, 32'h0);
        chk("pm_rd", pm_rd_o, 1'b1);
        wait_flag(2, n);
        chk("prog_rdata", prog_rdata_o, 16'h0F0D);
        go(5'h04, 24'h000222, 2'h1, 32'h0);
        chk("dm_b_addr", dm_b_addr_o, 24'h000222);
        wait_flag(1, n);
        chk("x2 latency", n, 2);
        chk("x2_rdata", x2_rdata_o, 16'h3E1E);
        go(5'h06, 24'h000300, 2'h1, 32'h00005555);
        chk("stall", {stall_o, dm_a_wr_o, dm_b_rd_o}, 3'h6);
        wait_flag(1, n);
        chk("deferred x2", n, 3);
        chk("x2 collide", x2_rdata_o, 16'h3F3C);
    endtask

    task automatic t_trigger();
        int n;
        wait_flag(3, n);
        wait_flag(3, n);
        chk("period", n, period_i + 16'h0001);
        @(posedge clk_i);
        alt_mode_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        pwm_reload_i <= 1'b1;
        @(posedge clk_i);
        pwm_reload_i <= 1'b0;
        #1;
        wait_flag(3, n);
        chk("delay", n, delay_i + 16'h0001);
    endtask

    // ************************************************
    // clock and main sequence
    // ************************************************
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        repeat (20) @(posedge clk_i);
        #1;
        chk("reset adc", adc_start_o, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        t_primary();
        t_periph_flash();
        t_prog_sec();
        t_trigger();
        end_of_test();
    end
endmodule
